// [mfr_core.sv]
/*
  Fault-recovery and upstream transmit gating for a cable modem MAC.
  Assumes message events arrive as one-cycle pulses from the MAC
  receive path on the system clock, already CRC checked.
*/
// Operation
// - Declare sync lost after the lost-sync interval without a SYNC.
// - While sync is lost keep upstream off and keep reacquiring.
// - No upstream transmission before a usable descriptor arrives.
// - T1 timeout waiting for a descriptor: stay silent, scan next channel.
// - Bad descriptor or count-mismatched MAP stops upstream, starts T1.
// - T1 expiry during descriptor suspension resets the MAC.
// - Transmit only under a valid bandwidth grant.
// - A lost MAP silences upstream for the span it described.
// - Ranging timeout resends the request up to the retry limit.
// - Ranging retries exhausted resets the MAC.
// - Registration timeout resends; exhausted retries reset the MAC.
// - Usable descriptor needs legal profiles; may require matching counts.
// - Data packets with bad CRC are dropped, higher layers recover.
// - Cut transmitter if carrier stays on beyond the longest burst.
// - Lost-sync interval is at most the stated maximum.
// - Ranging retry limit is at least the stated minimum.
// - Registration retry limit is at least the stated minimum.
// - Management messages failing CRC are discarded.
`timescale 1ns/100ps
module mfr_core
  import mfr_pkg::*;
#(
  parameter int LOST_SYNC_CYCLES = LOST_SYNC_CYC,
  parameter int T1_CYCLES        = T1_CYC,
  parameter int RNG_TMO_CYCLES   = RNG_TMO_CYC,
  parameter int REG_TMO_CYCLES   = REG_TMO_CYC,
  parameter int MAX_BURST_CYCLES = MAX_BURST_CYC,
  parameter int RNG_RETRY_MAX    = RNG_RETRIES,
  parameter int REG_RETRY_MAX    = REG_RETRIES
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              sync_rx_i,
  input  wire logic              ucd_rx_i,
  input  wire logic              ucd_legal_i,
  input  wire logic [CCC_W-1:0]  ucd_ccc_i,
  input  wire logic              map_rx_i,
  input  wire logic [CCC_W-1:0]  map_ucd_cnt_i,
  input  wire logic              map_lost_i,
  input  wire logic [SPAN_W-1:0] map_lost_span_i,
  input  wire logic              match_req_i,
  input  wire logic              mgmt_crc_ok_i,
  input  wire logic              data_rx_i,
  input  wire logic              data_crc_ok_i,
  input  wire logic              rng_sent_i,
  input  wire logic              rng_rsp_i,
  input  wire logic              reg_sent_i,
  input  wire logic              reg_rsp_i,
  input  wire logic              grant_i,
  input  wire logic              carrier_on_i,
  output logic                   tx_permit_o,
  output logic                   sync_lost_o,
  output logic                   scan_next_o,
  output logic                   mac_reset_o,
  output logic                   rng_resend_o,
  output logic                   reg_resend_o,
  output logic                   data_accept_o,
  output logic                   tx_kill_o,
  output mfr_state_t             state_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mfr_tmr_if t1 ();
  mfr_state_t         state_reg;
  logic [CNT_W-1:0]   sync_cnt_reg;
  logic               sync_lost_reg;
  logic               ucd_held_reg;
  logic               suspend_reg;
  logic [CCC_W-1:0]   ccc_reg;
  logic [SPAN_W-1:0]  mute_cnt_reg;
  logic [CNT_W-1:0]   rsp_cnt_reg;
  logic               rsp_wait_reg;
  logic [RETRY_W-1:0] retry_reg;
  logic [CNT_W-1:0]   carrier_cnt_reg;
  logic               kill_reg;
  logic               permit_reg;
  logic               scan_reg;
  logic               reset_reg;
  logic               rng_rs_reg;
  logic               reg_rs_reg;
  logic               data_ok_reg;
  logic               ucd_ok;
  logic               map_bad;
  logic               mgmt_ok;

  mfr_timer u_t1 (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .tif       (t1.tmr)
  );

  // Management messages with a bad CRC count as not received.
  // Discard bad CRC
  assign mgmt_ok = mgmt_crc_ok_i;
  assign ucd_ok  = ucd_legal_i
                   && (!match_req_i || !ucd_held_reg
                       || ucd_ccc_i == ccc_reg);
  assign map_bad = map_rx_i && mgmt_ok && ucd_held_reg
                   && (map_ucd_cnt_i != ccc_reg);

  // ----------------------------------------------------------------
  // Synchronisation watchdog
  // ----------------------------------------------------------------
  // Restart the count on each good SYNC; declare loss when it runs out.
  // Lost-sync count
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || reset_reg) begin
      sync_cnt_reg  <= '0;
      sync_lost_reg <= 1'b1;
    end else if (sync_rx_i && mgmt_ok) begin
      sync_cnt_reg  <= '0;
      sync_lost_reg <= 1'b0;
    end else if (!sync_lost_reg) begin
      if (sync_cnt_reg >= CNT_W'(LOST_SYNC_CYCLES - 1)) begin
        sync_lost_reg <= 1'b1;
      end else begin
        sync_cnt_reg <= sync_cnt_reg + CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Descriptor tracking and T1
  // ----------------------------------------------------------------
  // Hold the last usable descriptor; suspend on a bad one or bad MAP.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || reset_reg || state_reg == MFR_SCAN) begin
      ucd_held_reg <= 1'b0;
      suspend_reg  <= 1'b0;
      ccc_reg      <= '0;
    end else if (ucd_rx_i && mgmt_ok && ucd_ok) begin
      ucd_held_reg <= 1'b1;
      suspend_reg  <= map_bad;  // A bad MAP in the same cycle wins.
      ccc_reg      <= ucd_ccc_i;
    end else if (ucd_held_reg
                 && ((ucd_rx_i && mgmt_ok && !ucd_ok) || map_bad)) begin
      suspend_reg  <= 1'b1;
    end
  end

  // T1 runs while waiting for a first descriptor or while suspended.
  always_comb begin
    t1.load  = 1'b0;
    t1.value = CNT_W'(T1_CYCLES);
    t1.stop  = ucd_rx_i && mgmt_ok && ucd_ok && !map_bad;
    if (state_reg == MFR_SCAN && !sync_lost_reg) begin
      t1.load = 1'b1;
    end else if (ucd_held_reg && !suspend_reg
                 && ((ucd_rx_i && mgmt_ok && !ucd_ok) || map_bad)) begin
      t1.load = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Initialisation sequence and retries
  // ----------------------------------------------------------------
  // Step through scan, descriptor wait, ranging, registration.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg    <= MFR_SCAN;
      rsp_wait_reg <= 1'b0;
      rsp_cnt_reg  <= '0;
      retry_reg    <= '0;
      scan_reg     <= 1'b0;
      reset_reg    <= 1'b0;
      rng_rs_reg   <= 1'b0;
      reg_rs_reg   <= 1'b0;
    end else begin
      scan_reg   <= 1'b0;
      reset_reg  <= 1'b0;
      rng_rs_reg <= 1'b0;
      reg_rs_reg <= 1'b0;
      if (rsp_wait_reg) begin
        rsp_cnt_reg <= rsp_cnt_reg + CNT_W'(1);
      end
      if (reset_reg) begin
        state_reg    <= MFR_SCAN;
        rsp_wait_reg <= 1'b0;
        retry_reg    <= '0;
      end else begin
        case (state_reg)
          MFR_SCAN: begin
            if (!sync_lost_reg) begin
              state_reg <= MFR_WAIT_UCD;
            end
          end
          MFR_WAIT_UCD: begin
            if (ucd_held_reg) begin
              state_reg <= MFR_RANGING;
              retry_reg <= '0;
            end else if (t1.expired) begin
              state_reg <= MFR_SCAN;
              scan_reg  <= 1'b1;
            end
          end
          MFR_RANGING: begin
            if (rng_sent_i) begin
              rsp_wait_reg <= 1'b1;
              rsp_cnt_reg  <= '0;
            end else if (rsp_wait_reg && rng_rsp_i && mgmt_ok) begin
              rsp_wait_reg <= 1'b0;
              retry_reg    <= '0;
              state_reg    <= MFR_REGISTER;
            end else if (rsp_wait_reg
                   && rsp_cnt_reg >= CNT_W'(RNG_TMO_CYCLES - 1)) begin
              rsp_wait_reg <= 1'b0;
              if (retry_reg >= RETRY_W'(RNG_RETRY_MAX)) begin
                reset_reg <= 1'b1;
              end else begin
                retry_reg  <= retry_reg + RETRY_W'(1);
                rng_rs_reg <= 1'b1;
              end
            end
          end
          MFR_REGISTER: begin
            if (reg_sent_i) begin
              rsp_wait_reg <= 1'b1;
              rsp_cnt_reg  <= '0;
            end else if (rsp_wait_reg && reg_rsp_i && mgmt_ok) begin
              rsp_wait_reg <= 1'b0;
              state_reg    <= MFR_OPERATE;
            end else if (rsp_wait_reg
                   && rsp_cnt_reg >= CNT_W'(REG_TMO_CYCLES - 1)) begin
              rsp_wait_reg <= 1'b0;
              if (retry_reg >= RETRY_W'(REG_RETRY_MAX)) begin
                reset_reg <= 1'b1;
              end else begin
                retry_reg  <= retry_reg + RETRY_W'(1);
                reg_rs_reg <= 1'b1;
              end
            end
          end
          MFR_OPERATE: begin
          end
          default: state_reg <= MFR_SCAN;
        endcase
        if (suspend_reg && t1.expired) begin
          reset_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit gating
  // ----------------------------------------------------------------
  // Mute for the span of a MAP lost to a reception error.
  // Lost MAP mute
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mute_cnt_reg <= '0;
    end else if (map_lost_i && map_lost_span_i > mute_cnt_reg) begin
      mute_cnt_reg <= map_lost_span_i;
    end else if (mute_cnt_reg != '0) begin
      mute_cnt_reg <= mute_cnt_reg - SPAN_W'(1);
    end
  end

  // Runaway carrier guard: count continuous carrier, kill on overrun.
  // Carrier runaway cut
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !carrier_on_i) begin
      carrier_cnt_reg <= '0;
      kill_reg        <= 1'b0;
    end else if (carrier_cnt_reg >= CNT_W'(MAX_BURST_CYCLES - 1)) begin
      kill_reg <= 1'b1;
    end else begin
      carrier_cnt_reg <= carrier_cnt_reg + CNT_W'(1);
    end
  end

  // Permit upstream only when every condition holds this cycle.
  // Transmit permit
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      permit_reg <= 1'b0;
    end else begin
      permit_reg <= !sync_lost_reg && ucd_held_reg && !suspend_reg
                    && grant_i && !map_lost_i && mute_cnt_reg == '0
                    && !kill_reg && !reset_reg
                    && state_reg != MFR_SCAN;
    end
  end

  // Pass data upward only when its CRC holds.
  // Drop bad data
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      data_ok_reg <= 1'b0;
    end else begin
      data_ok_reg <= data_rx_i && data_crc_ok_i;
    end
  end

  assign tx_permit_o   = permit_reg;
  assign sync_lost_o   = sync_lost_reg;
  assign scan_next_o   = scan_reg;
  assign mac_reset_o   = reset_reg;
  assign rng_resend_o  = rng_rs_reg;
  assign reg_resend_o  = reg_rs_reg;
  assign data_accept_o = data_ok_reg;
  assign tx_kill_o     = kill_reg;
  assign state_o       = state_reg;

endmodule : mfr_core

// [mfr_core_props.sv]
/*
  Checker of the fault-recovery core, watching its ports only.
  Assumes one clock and a synchronous active-high reset; bound below.
*/
`timescale 1ns/100ps
module mfr_core_props
  import mfr_pkg::*;
#(
  parameter int LOST_SYNC_CYCLES = LOST_SYNC_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              sync_rx_i,
  input  wire logic              mgmt_crc_ok_i,
  input  wire logic              map_lost_i,
  input  wire logic [SPAN_W-1:0] map_lost_span_i,
  input  wire logic              data_rx_i,
  input  wire logic              data_crc_ok_i,
  input  wire logic              grant_i,
  input  wire logic              carrier_on_i,
  input  wire logic              tx_permit_o,
  input  wire logic              sync_lost_o,
  input  wire logic              mac_reset_o,
  input  wire logic              rng_resend_o,
  input  wire logic              reg_resend_o,
  input  wire logic              data_accept_o,
  input  wire logic              tx_kill_o,
  input  wire mfr_state_t        state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic [31:0] quiet_reg;

  // Counts the cycles since the last SYNC with a good CRC.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || (sync_rx_i && mgmt_crc_ok_i)) quiet_reg <= 32'h0;
    else if (quiet_reg != 32'hffffffff) quiet_reg <= quiet_reg + 32'h1;
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  sequence s_mute;
    !tx_permit_o [*2];
  endsequence
  property p_quiet;
    quiet_reg > 32'(LOST_SYNC_CYCLES + 2) |-> sync_lost_o;
  endproperty
  property p_lost_off;
    tx_permit_o |-> !(sync_lost_o && $past(sync_lost_o));
  endproperty
  property p_no_ucd;
    tx_permit_o |-> !(state_o inside {MFR_SCAN, MFR_WAIT_UCD} &&
                      $past(state_o) inside {MFR_SCAN, MFR_WAIT_UCD});
  endproperty
  property p_grant;
    tx_permit_o |-> $past(grant_i);
  endproperty
  property p_map_lost;
    map_lost_i && map_lost_span_i > 16'h0004 |-> ##2 s_mute;
  endproperty
  property p_reinit;
    mac_reset_o |=> state_o == MFR_SCAN && !tx_permit_o;
  endproperty
  property p_rng;
    rng_resend_o |-> state_o == MFR_RANGING;
  endproperty
  property p_reg;
    reg_resend_o |-> state_o == MFR_REGISTER;
  endproperty
  property p_data;
    data_accept_o |-> $past(data_rx_i && data_crc_ok_i);
  endproperty
  property p_bad_sync;
    sync_rx_i && !mgmt_crc_ok_i && sync_lost_o |=> sync_lost_o;
  endproperty
  property p_kill;
    tx_kill_o |-> $past(carrier_on_i);
  endproperty

  a_quiet: assert property (p_quiet)
    else $error("sync not declared lost after silence");
  a_lost_off: assert property (p_lost_off)
    else $error("permit while sync lost");
  a_no_ucd: assert property (p_no_ucd)
    else $error("permit before usable descriptor");
  a_grant: assert property (p_grant)
    else $error("permit without grant");
  a_map_lost: assert property (p_map_lost)
    else $error("permit during lost map span");
  a_reinit: assert property (p_reinit)
    else $error("mac reset did not restart scan");
  a_rng: assert property (p_rng)
    else $error("ranging resend outside ranging");
  a_reg: assert property (p_reg)
    else $error("registration resend outside registration");
  a_data: assert property (p_data)
    else $error("data accepted without good crc");
  a_bad_sync: assert property (p_bad_sync)
    else $error("bad crc sync was used");
  a_kill: assert property (p_kill)
    else $error("kill without carrier");
endmodule : mfr_core_props

bind mfr_core mfr_core_props #(
  .LOST_SYNC_CYCLES(LOST_SYNC_CYCLES)
) props_i (.clk_sys_i, .sys_rst_i, .sync_rx_i, .mgmt_crc_ok_i,
  .map_lost_i, .map_lost_span_i, .data_rx_i, .data_crc_ok_i, .grant_i,
  .carrier_on_i, .tx_permit_o, .sync_lost_o, .mac_reset_o,
  .rng_resend_o, .reg_resend_o, .data_accept_o, .tx_kill_o, .state_o);

// [mfr_headend_model.sv]
/*
  Headend scheduler model: grants, ranging and registration replies.
  Assumes the bench clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module mfr_headend_model #(
  parameter int UCC_RETRY_MAX = 3
) (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       rng_sent_i,
  input  wire logic       reg_sent_i,
  input  wire logic       rng_ans_i,
  input  wire logic       reg_ans_i,
  input  wire logic [3:0] lat_i,
  input  wire logic       ucc_start_i,
  output logic            grant_o,
  output logic            rng_rsp_o,
  output logic            reg_rsp_o,
  output logic            unreach_o
);
  logic [15:0] lfsr_reg;
  logic [4:0]  rng_reg;
  logic [4:0]  reg_reg;
  logic [3:0]  ucc_reg;

  // Grants follow a pseudo-random slot pattern.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) lfsr_reg <= 16'hace1;
    else lfsr_reg <= {lfsr_reg[14:0], ^(lfsr_reg & 16'hb400)};
    grant_o <= lfsr_reg[0] && !sys_rst_i;
  end

  // Replies come lat_i + 1 cycles after a request, only when enabled.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) rng_reg <= 5'h0;
    else if (rng_sent_i && rng_ans_i) rng_reg <= {1'b0, lat_i} + 5'h1;
    else if (rng_reg != 5'h0) rng_reg <= rng_reg - 5'h1;
    if (sys_rst_i) reg_reg <= 5'h0;
    else if (reg_sent_i && reg_ans_i) reg_reg <= {1'b0, lat_i} + 5'h1;
    else if (reg_reg != 5'h0) reg_reg <= reg_reg - 5'h1;
    rng_rsp_o <= rng_reg == 5'h1;
    reg_rsp_o <= reg_reg == 5'h1;
  end

  // Channel change retries
  // Each cycle stands for one unanswered change request period.
  always_ff @(posedge clk_sys_i) begin
    if (ucc_start_i) ucc_reg <= 4'h0;
    else if (ucc_reg <= 4'(UCC_RETRY_MAX)) ucc_reg <= ucc_reg + 4'h1;
  end
  assign unreach_o = ucc_reg > 4'(UCC_RETRY_MAX);
endmodule : mfr_headend_model

// [mfr_pkg.sv]
/*
  Package for the modem MAC fault-recovery block: timing constants,
  retry limits and state enumerations.
  Assumes a 125 MHz system clock.
*/
package mfr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int LOST_SYNC_MS     = 600;
  localparam int LOST_SYNC_CYC    = LOST_SYNC_MS * 1000 * CLK_MHZ;
  localparam int T1_MS            = 2000;
  localparam int T1_CYC           = T1_MS * 1000 * CLK_MHZ;
  localparam int RNG_TMO_MS       = 200;
  localparam int RNG_TMO_CYC      = RNG_TMO_MS * 1000 * CLK_MHZ;
  localparam int REG_TMO_MS       = 3000;
  localparam int REG_TMO_CYC      = REG_TMO_MS * 1000 * CLK_MHZ;
  localparam int MAX_BURST_US     = 2000;
  localparam int MAX_BURST_CYC    = MAX_BURST_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Retry limits and widths
  // ----------------------------------------------------------------
  localparam int RNG_RETRIES      = 16;
  localparam int REG_RETRIES      = 3;
  localparam int CNT_W            = 32;
  localparam int RETRY_W          = 8;
  localparam int CCC_W            = 8;
  localparam int SPAN_W           = 16;

  // Initialisation sequence of the modem MAC.
  typedef enum logic [2:0] {
    MFR_SCAN,
    MFR_WAIT_UCD,
    MFR_RANGING,
    MFR_REGISTER,
    MFR_OPERATE
  } mfr_state_t;

endpackage : mfr_pkg

// [mfr_timer.sv]
/*
  Countdown timer: loaded with a cycle count, pulses expired for one
  cycle when the count runs out. Stop cancels a running count.
  Assumes synchronous active-high reset on the system clock.
*/
`timescale 1ns/100ps
module mfr_timer
  import mfr_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  mfr_tmr_if.tmr    tif
);

  logic [CNT_W-1:0] cnt_reg;
  logic             run_reg;
  logic             exp_reg;

  // Count down while running; expire once on reaching one.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      exp_reg <= 1'b0;
      if (tif.load) begin
        cnt_reg <= tif.value;
        run_reg <= 1'b1;
      end else if (tif.stop) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        if (cnt_reg <= CNT_W'(1)) begin
          run_reg <= 1'b0;
          exp_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - CNT_W'(1);
        end
      end
    end
  end

  assign tif.expired = exp_reg;

endmodule : mfr_timer

// [mfr_tmr_if.sv]
/*
  Interface carrying a timer request and its expiry between the
  recovery core and its countdown timer.
  Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
interface mfr_tmr_if;
  import mfr_pkg::*;
  logic             load;
  logic [CNT_W-1:0] value;
  logic             stop;
  logic             expired;

  modport ctrl (output load, output value, output stop, input expired);
  modport tmr  (input load, input value, input stop, output expired);
endinterface : mfr_tmr_if

// [testbench.sv]
/*
  Self-checking bench of the fault-recovery core and headend model.
  Assumes the package, interface and design files compile first.
*/
`timescale 1ns/100ps
module testbench;
  import mfr_pkg::*;
  localparam int LS = 50, T1 = 80, TMO = 20, KB = 30;
  logic clk_sys_i, sys_rst_i, sync_tick, sync_en, ucd_legal, crc_ok;
  logic data_ok, carrier, rng_ans, reg_ans, grant, rng_rsp, reg_rsp;
  logic tx_permit, sync_lost, scan_next, mac_reset, rng_rs, reg_rs;
  logic acc, kill, last_g, match_req;
  logic [6:0] pls;
  logic [7:0] ccc, map_cnt;
  logic [15:0] span;
  logic [3:0] lat;
  logic [3:0] obs;
  mfr_state_t state;
  int miscompares, tests_run, n, tick_cnt;

  assign obs = {mac_reset, scan_next, rng_rs, reg_rs};

  mfr_core #(.LOST_SYNC_CYCLES(LS), .T1_CYCLES(T1), .RNG_TMO_CYCLES(TMO),
    .REG_TMO_CYCLES(TMO), .MAX_BURST_CYCLES(KB)) mfr_core_i (
    .clk_sys_i, .sys_rst_i, .sync_rx_i(pls[0] | sync_tick),
    .ucd_rx_i(pls[1]), .ucd_legal_i(ucd_legal), .ucd_ccc_i(ccc),
    .map_rx_i(pls[2]), .map_ucd_cnt_i(map_cnt), .map_lost_i(pls[6]),
    .map_lost_span_i(span), .match_req_i(match_req),
    .mgmt_crc_ok_i(crc_ok), .data_rx_i(pls[5]), .data_crc_ok_i(data_ok),
    .rng_sent_i(pls[3]), .rng_rsp_i(rng_rsp), .reg_sent_i(pls[4]),
    .reg_rsp_i(reg_rsp), .grant_i(grant), .carrier_on_i(carrier),
    .tx_permit_o(tx_permit), .sync_lost_o(sync_lost),
    .scan_next_o(scan_next), .mac_reset_o(mac_reset),
    .rng_resend_o(rng_rs), .reg_resend_o(reg_rs), .data_accept_o(acc),
    .tx_kill_o(kill), .state_o(state));

  mfr_headend_model mfr_headend_model_i (.clk_sys_i, .sys_rst_i,
    .rng_sent_i(pls[3]), .reg_sent_i(pls[4]), .rng_ans_i(rng_ans),
    .reg_ans_i(reg_ans), .lat_i(lat), .ucc_start_i(sys_rst_i),
    .grant_o(grant), .rng_rsp_o(rng_rsp), .reg_rsp_o(reg_rsp),
    .unreach_o());

  // Clock of 8 ns and a SYNC every 20 cycles while enabled.
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    tick_cnt = (tick_cnt + 1) % 20;
    sync_tick = sync_en && tick_cnt == 0;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  function automatic logic exp_permit(logic g, logic op);
    return g && op;
  endfunction : exp_permit

  task automatic check(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic pulse(int i);
    @(negedge clk_sys_i) pls[i] = 1'b1;
    @(negedge clk_sys_i) pls[i] = 1'b0;
  endtask : pulse

  task automatic wait_on(int sel, int lim, output int cyc);
    cyc = -1;
    for (int k = 0; k < lim && cyc < 0; k++) begin
      @(negedge clk_sys_i);
      if (obs[sel]) cyc = k;
    end
  endtask : wait_on

  task automatic bring_up(logic ra, logic ga);
    rng_ans = ra;
    reg_ans = ga;
    sync_en = 1'b1;
    lat = 4'($urandom_range(7));
    repeat (30) @(negedge clk_sys_i);
    ucd_legal = 1'b0;
    pulse(1);
    check("state_illegal", 8'(MFR_WAIT_UCD), 8'(state));
    check("permit_no_ucd", 8'h0, 8'(tx_permit));
    ucd_legal = 1'b1;
    ccc = 8'($urandom);
    map_cnt = ccc;
    pulse(1);
    @(negedge clk_sys_i);
    check("state_ranging", 8'(MFR_RANGING), 8'(state));
    if (ra) begin
      pulse(3);
      repeat (TMO - 4) @(negedge clk_sys_i);
      check("state_register", 8'(MFR_REGISTER), 8'(state));
    end
    if (ra && ga) begin
      pulse(4);
      repeat (TMO - 4) @(negedge clk_sys_i);
      check("state_operate", 8'(MFR_OPERATE), 8'(state));
    end
  endtask : bring_up

  task automatic retry_run(int si, int oi, int lim);
    int c, w;
    c = 0;
    pulse(si);
    repeat (lim) begin
      wait_on(oi, TMO + 8, w);
      if (w >= 0) c++;
      if (w >= 0) pulse(si);
    end
    check("resends", 8'(lim), 8'(c));
    wait_on(3, TMO + 8, w);
    check("retry_reset", 8'h1, 8'(w >= 0));
  endtask : retry_run

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Watchdog against a hung wait.
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    miscompares++;
    final_report();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {sync_tick, sync_en, ucd_legal, data_ok, carrier, match_req} = '0;
    {rng_ans, reg_ans, pls, ccc, map_cnt, span, lat} = '0;
    {miscompares, tests_run, tick_cnt} = '0;
    crc_ok = 1'b1;
    sys_rst_i = 1'b1;
    void'($urandom(39));
    repeat (8) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    check("reset_lost", 8'h1, 8'(sync_lost));
    check("reset_state", 8'(MFR_SCAN), 8'(state));
    bring_up(1'b1, 1'b1);
    last_g = 1'b0;
    for (int k = 0; k < 200; k++) begin
      @(negedge clk_sys_i);
      if (k > 0) begin
        check("permit", 8'(exp_permit(last_g, 1'b1)), 8'(tx_permit));
      end
      last_g = grant;
    end
    for (int k = 0; k < 4; k++) begin
      data_ok = k[0];
      pulse(5);
      check("data_accept", 8'(k[0]), 8'(acc));
    end
    span = 16'h000c;
    pulse(6);
    repeat (8) begin
      @(negedge clk_sys_i);
      check("permit_map_lost", 8'h0, 8'(tx_permit));
    end
    carrier = 1'b1;
    repeat (KB + 4) @(negedge clk_sys_i);
    check("kill_on", 8'h1, 8'(kill));
    carrier = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check("kill_off", 8'h0, 8'(kill));
    $display("test operate done");
    map_cnt = ccc + 8'h1;
    pulse(2);
    @(negedge clk_sys_i);
    check("permit_mismatch", 8'h0, 8'(tx_permit));
    // A descriptor with another count must not lift the suspension.
    match_req = 1'b1;
    ccc = ccc + 8'h2;
    pulse(1);
    wait_on(3, T1 + 10, n);
    check("t1_reset", 8'h1, 8'(n >= 0));
    match_req = 1'b0;
    $display("test descriptor done");
    bring_up(1'b0, 1'b0);
    retry_run(3, 1, RNG_RETRIES);
    bring_up(1'b1, 1'b0);
    retry_run(4, 0, REG_RETRIES);
    $display("test retries done");
    wait_on(2, T1 + 60, n);
    check("scan_next", 8'h1, 8'(n >= 0));
    sync_en = 1'b0;
    crc_ok = 1'b0;
    repeat (4) pulse(0);
    crc_ok = 1'b1;
    repeat (LS + 2) @(negedge clk_sys_i);
    check("sync_lost", 8'h1, 8'(sync_lost));
    check("permit_lost", 8'h0, 8'(tx_permit));
    // A SYNC with a bad CRC must not end the loss.
    crc_ok = 1'b0;
    pulse(0);
    crc_ok = 1'b1;
    @(negedge clk_sys_i);
    check("bad_sync_lost", 8'h1, 8'(sync_lost));
    $display("test sync loss done");
    final_report();
  end
endmodule : testbench
